// ==== hdl/flash_guard_pkg.sv ====
// Constants for the self-programming flash protection block.
// Assumes a single 200 MHz core clock; no timing figures are needed.
package flash_guard_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int          PTR_W          = 16;     // Pointer register width
  localparam int          WORD_IN_PAGE_W = 5;      // Word-in-page field width
  localparam int          PAGE_W         = 15 - WORD_IN_PAGE_W; // Page field
  localparam int          PAGE_LSB       = 1 + WORD_IN_PAGE_W;  // Page position
  localparam int          BYTE_SEL_POS   = 0;      // Byte select bit position
  localparam logic [14:0] APP_RESET_ADDR = 15'h0000; // Application reset word
  localparam logic [14:0] LOADER_START   = 15'h0F00; // Default loader start

  // ----------------------------------------------------------------
  // Lock bit layout and reset values
  // ----------------------------------------------------------------
  localparam int         LOCK_APP_LO    = 0;       // Application lower bit
  localparam int         LOCK_APP_HI    = 1;       // Application upper bit
  localparam int         LOCK_LDR_LO    = 2;       // Loader lower bit
  localparam int         LOCK_LDR_HI    = 3;       // Loader upper bit
  localparam logic [3:0] LOCK_ERASED    = 4'hF;    // All unprogrammed
  localparam int         DATA_LOCK_LSB  = 2;       // Lock bits in data byte

  // ----------------------------------------------------------------
  // Operations requested by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BUF_LOAD,
    OP_PAGE_ERASE,
    OP_PAGE_WRITE,
    OP_LOCK_SET,
    OP_READ
  } flash_op_t;

endpackage

// ==== hdl/section_lock_mode.sv ====
// Decodes one lock bit pair into the permissions for one flash section.
// Assumes pair bits already resynchronised and stable in the core domain.
`timescale 1ns/10ps
`default_nettype none
module section_lock_mode
(
  input  wire logic lock_upper_in,       // Upper bit, 0 = programmed
  input  wire logic lock_lower_in,       // Lower bit, 0 = programmed
  output logic      write_block_out,     // Store writes refused
  output logic      cross_read_block_out,// Reads from other section refused
  output logic      irq_block_out        // Interrupts gated in this section
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Lower bit programmed blocks writes (pairs 1/0 and 0/0)
  assign write_block_out      = ~lock_lower_in;
  // Upper bit programmed blocks cross reads (pairs 0/0 and 0/1)
  assign cross_read_block_out = ~lock_upper_in;
  // Same modes gate interrupts
  assign irq_block_out        = ~lock_upper_in;

endmodule
`default_nettype wire

// ==== hdl/boot_section_flash_protection.sv ====
// Access control and address latching for flash self-programming.
// Assumes the core presents one request per cycle with a one-cycle strobe;
// fuse, erase and external programming inputs arrive from other domains.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Lock bits cleared only by chip erase; reset also loads LOCK_ERASED here
// - Write lock mode ignored for store writes
// - Read/write lock mode ignored for self access
// - Application pair 11 means no restriction
// - Application pairs 10,00 block application writes
// - Application pairs 00,01 block loader-side reads
// - Application modes gate interrupts in application
// - Loader pair 11 means no restriction
// - Loader pairs 10,00 block loader writes
// - Loader pairs 00,01 block application-side reads
// - Loader modes gate interrupts in loader
// - Reset vector chosen by boot reset fuse
// - Fuses not changeable by core instructions
// - Pointer splits into page and word
// - Address latched when operation starts
// - Lock setting ignores the pointer
// - Pointer low bit selects read byte
// - Buffer takes one word per store
// - Store ignored unless issued from loader
module boot_section_flash_protection
  import flash_guard_pkg::*;
#(
  parameter logic [14:0] LOADER_START_ADDR = flash_guard_pkg::LOADER_START
)
(
  input  wire logic                         ref_clk_in,      // Core clock
  input  wire logic                         resetn_in,       // Async reset
  input  wire logic                         boot_reset_select_fuse_in,
  input  wire logic                         chip_erase_in,   // Ext. erase
  input  wire logic                         ext_lock_wr_in,  // Ext. lock pgm
  input  wire logic [3:0]                   ext_lock_data_in,// 0 programs
  input  wire logic [1:0]                   lock_mode_in,    // General lock
  input  wire logic                         vectors_in_loader_in,
  input  wire logic                         exec_in_loader_in,
  input  wire logic                         req_valid_in,    // Request strobe
  input  wire flash_guard_pkg::flash_op_t   req_op_in,       // Operation
  input  wire logic [PTR_W-1:0]             pointer_in,      // Pointer reg
  input  wire logic [7:0]                   lock_data_in,    // Lock data byte
  output logic                              grant_out,       // Request done
  output logic                              deny_out,        // Request refused
  output logic [PAGE_W-1:0]                 page_index_field_out,
  output logic [WORD_IN_PAGE_W-1:0]         word_in_page_field_out,
  output logic                              byte_select_bit_out,
  output flash_guard_pkg::flash_op_t        op_out,          // Latched op
  output logic [3:0]                        lock_bits_out,   // Lock state
  output logic [14:0]                       reset_vector_out,
  output logic                              irq_enable_out   // Irq gate
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta_r;      // Reset release stage one
  logic       rst_n_r;         // Reset used by the design
  logic [3:0] pin_meta_r;      // First synchroniser stage
  logic [3:0] pin_sync_r;      // Second synchroniser stage
  logic       fuse_s;          // Boot reset fuse, synced
  logic       erase_s;         // Chip erase level, synced
  logic       ext_wr_s;        // External lock write level, synced
  logic       ext_wr_d_r;      // Edge detect history
  logic       erase_d_r;       // Edge detect history

  // Reset deasserts synchronously to avoid a ragged release
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Pins from other domains; only the second stage is read
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= {ext_lock_wr_in, chip_erase_in,
                     boot_reset_select_fuse_in, 1'b0};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign fuse_s   = pin_sync_r[1];
  assign erase_s  = pin_sync_r[2];
  assign ext_wr_s = pin_sync_r[3];

  // Edge history for the external strobes
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ext_wr_d_r <= 1'b0;
      erase_d_r  <= 1'b0;
    end
    else
    begin
      ext_wr_d_r <= ext_wr_s;
      erase_d_r  <= erase_s;
    end
  end

  // ----------------------------------------------------------------
  // Lock bit storage
  // ----------------------------------------------------------------
  logic [3:0] lock_r;          // Boot lock bits, 0 = programmed
  logic       self_lock_ok;    // Core lock setting accepted
  logic       erase_rise;      // Chip erase command edge
  logic       ext_rise;        // External lock write edge

  assign erase_rise   = erase_s & ~erase_d_r;
  assign ext_rise     = ext_wr_s & ~ext_wr_d_r;
  // Pointer not consulted; general lock mode not consulted
  assign self_lock_ok = req_valid_in && req_op_in == OP_LOCK_SET
                        && exec_in_loader_in;

  // Programming only clears bits; erase or reset is the only way back to ones
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      lock_r <= LOCK_ERASED;
    else if (erase_rise)
      lock_r <= LOCK_ERASED;
    else
    begin
      if (self_lock_ok)
        lock_r <= lock_r & lock_data_in[DATA_LOCK_LSB +: 4];
      else if (ext_rise)
        lock_r <= lock_r & ext_lock_data_in;
    end
  end

  assign lock_bits_out = lock_r;

  // ----------------------------------------------------------------
  // Section mode decode
  // ----------------------------------------------------------------
  logic app_wr_blk;            // Application writes refused
  logic app_rd_blk;            // Loader reads from application refused
  logic app_irq_blk;           // Interrupt gate for application
  logic ldr_wr_blk;            // Loader writes refused
  logic ldr_rd_blk;            // Application reads from loader refused
  logic ldr_irq_blk;           // Interrupt gate for loader

  // Pair 11 yields no restriction at all
  section_lock_mode app_mode
  (
    .lock_upper_in        (lock_r[LOCK_APP_HI]),
    .lock_lower_in        (lock_r[LOCK_APP_LO]),
    .write_block_out      (app_wr_blk),
    .cross_read_block_out (app_rd_blk),
    .irq_block_out        (app_irq_blk)
  );

  section_lock_mode ldr_mode
  (
    .lock_upper_in        (lock_r[LOCK_LDR_HI]),
    .lock_lower_in        (lock_r[LOCK_LDR_LO]),
    .write_block_out      (ldr_wr_blk),
    .cross_read_block_out (ldr_rd_blk),
    .irq_block_out        (ldr_irq_blk)
  );

  // ----------------------------------------------------------------
  // Request decision
  // ----------------------------------------------------------------
  logic        tgt_loader;     // Pointer targets loader section
  logic        is_store;       // Store-program class operation
  logic        allow;          // Request permitted
  logic [14:0] tgt_word;       // Word address from pointer

  assign tgt_word   = pointer_in[PTR_W-1:1];
  assign tgt_loader = tgt_word >= LOADER_START_ADDR;
  assign is_store   = req_op_in == OP_BUF_LOAD
                      || req_op_in == OP_PAGE_ERASE
                      || req_op_in == OP_PAGE_WRITE;

  // General lock_mode_in deliberately unused here
  always_comb
  begin
    allow = 1'b1;
    if (req_op_in == OP_LOCK_SET)
      allow = exec_in_loader_in;
    else if (is_store)
    begin
      if (!exec_in_loader_in)
        allow = 1'b0;
      else if (tgt_loader)
        allow = ~ldr_wr_blk;
      else
        allow = ~app_wr_blk;
    end
    else if (req_op_in == OP_READ)
    begin
      if (exec_in_loader_in && !tgt_loader)
        allow = ~app_rd_blk;
      else if (!exec_in_loader_in && tgt_loader)
        allow = ~ldr_rd_blk;
    end
  end

  // ----------------------------------------------------------------
  // Operation latch
  // ----------------------------------------------------------------
  logic accept;                // Request taken this cycle
  assign accept = req_valid_in && req_op_in != OP_NONE && allow;

  // Pointer captured at start; later pointer changes do not matter
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      page_index_field_out   <= '0;
      word_in_page_field_out <= '0;
      byte_select_bit_out    <= 1'b0;
      op_out                 <= OP_NONE;
    end
    else if (accept && req_op_in != OP_LOCK_SET)
    begin
      page_index_field_out   <= pointer_in[PAGE_LSB +: PAGE_W];
      word_in_page_field_out <= pointer_in[1 +: WORD_IN_PAGE_W];
      byte_select_bit_out    <= pointer_in[BYTE_SEL_POS];
      op_out                 <= req_op_in;
    end
    else if (accept)
      op_out <= req_op_in;
    else
      op_out <= OP_NONE;
  end

  // One-cycle answer strobes
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      grant_out <= 1'b0;
      deny_out  <= 1'b0;
    end
    else
    begin
      grant_out <= accept;
      deny_out  <= req_valid_in && req_op_in != OP_NONE && !allow;
    end
  end

  // ----------------------------------------------------------------
  // Reset vector and interrupt gate
  // ----------------------------------------------------------------
  logic       vec_cap_r;       // Vector captured after release
  logic [1:0] vec_wait_r;      // Lets the fuse pass the synchroniser

  // Fuse only read from its pin; no core path writes it
  // Capture waits two edges so the sync stages hold the pin, not reset
  always_ff @(posedge ref_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      reset_vector_out <= APP_RESET_ADDR;
      vec_cap_r        <= 1'b0;
      vec_wait_r       <= 2'b00;
    end
    else if (vec_wait_r != 2'b11)
      vec_wait_r <= {vec_wait_r[0], 1'b1};
    else if (!vec_cap_r)
    begin
      reset_vector_out <= fuse_s ? APP_RESET_ADDR
                                 : LOADER_START_ADDR;
      vec_cap_r        <= 1'b1;
    end
  end

  always_comb
  begin
    irq_enable_out = 1'b1;
    if (!exec_in_loader_in && vectors_in_loader_in && app_irq_blk)
      irq_enable_out = 1'b0;
    else if (exec_in_loader_in && !vectors_in_loader_in && ldr_irq_blk)
      irq_enable_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence app_store_s;
    req_valid_in && is_store && exec_in_loader_in && !tgt_loader;
  endsequence

  chk_app_write_block: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    (app_store_s and !lock_r[LOCK_APP_LO]) |=> deny_out && !grant_out)
    else $error("application store not refused");

  chk_ldr_write_block: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    req_valid_in && is_store && exec_in_loader_in && tgt_loader
    && !lock_r[LOCK_LDR_LO] |=> deny_out)
    else $error("loader store not refused");

  chk_app_store_ignored: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    req_valid_in && is_store && !exec_in_loader_in |=> !grant_out)
    else $error("store from application executed");

  chk_app_read_block: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    req_valid_in && req_op_in == OP_READ && exec_in_loader_in
    && !tgt_loader && !lock_r[LOCK_APP_HI] |=> deny_out)
    else $error("protected application read granted");

  chk_ldr_read_block: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    req_valid_in && req_op_in == OP_READ && !exec_in_loader_in
    && tgt_loader && !lock_r[LOCK_LDR_HI] |=> deny_out)
    else $error("protected loader read granted");

  chk_free_access: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    req_valid_in && req_op_in == OP_READ && lock_r == LOCK_ERASED
    |=> grant_out)
    else $error("unrestricted read refused");

  chk_lock_only_clear: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    !erase_rise |=> (lock_r & ~$past(lock_r)) == 4'h0)
    else $error("lock bit returned to one without erase");

  chk_erase_unlocks: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    erase_rise |=> lock_r == LOCK_ERASED)
    else $error("chip erase left lock bits programmed");

  chk_addr_latched: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    accept && req_op_in != OP_LOCK_SET
    |=> page_index_field_out == $past(pointer_in[PAGE_LSB +: PAGE_W])
        && byte_select_bit_out == $past(pointer_in[0]))
    else $error("address not latched at start");

  chk_irq_gate: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_r)
    !exec_in_loader_in && vectors_in_loader_in && !lock_r[LOCK_APP_HI]
    |-> !irq_enable_out)
    else $error("interrupt open in protected application");

endmodule
`default_nettype wire

// ==== dv/core_model.sv ====
// Processor core stand-in issuing program-memory requests to the guard.
// Assumes the guard takes a request at the edge after it is driven.
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  input  wire logic                           clk_in,
  input  wire logic                           grant_in,
  input  wire logic                           deny_in,
  output logic                                req_valid_out,
  output flash_guard_pkg::flash_op_t          req_op_out,
  output logic [flash_guard_pkg::PTR_W-1:0]   pointer_out,
  output logic [7:0]                          lock_data_out,
  output logic                                exec_in_loader_out
);
  import flash_guard_pkg::*;

  // ----------------------------------------------------------------
  // Idle values at time zero
  // ----------------------------------------------------------------
  initial
  begin
    req_valid_out      = 1'b0;
    req_op_out         = OP_NONE;
    pointer_out        = 16'h0000;
    lock_data_out      = 8'hFF;
    exec_in_loader_out = 1'b1;
  end

  // Move execution to the loader (1) or application (0) section
  task automatic place(input logic in_loader);
    @(posedge clk_in);
    exec_in_loader_out <= in_loader;
  endtask

  // One request; answer taken 1 ns after the taking edge
  task automatic issue(input flash_op_t op, input logic [15:0] ptr,
                       input logic [7:0] data, output logic [1:0] ans);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_op_out    <= op;
    pointer_out   <= ptr;
    lock_data_out <= data;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_op_out    <= OP_NONE;
    // Software reuses the pointer at once, so it never holds its value
    pointer_out   <= ~ptr;
    lock_data_out <= ~data;
    #1;
    ans = {grant_in, deny_in};
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the flash protection block.
// Assumes the core stand-in drives requests; bench owns the other pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import flash_guard_pkg::*;

  logic clk, rstn, fuse, erase, ext_wr, irq_en, vecs_ldr, exec_ldr;
  logic valid, grant, deny, bsel;
  logic [3:0] ext_data, locks;
  logic [1:0] gmode;
  flash_op_t op, op_q;
  logic [15:0] ptr;
  logic [7:0] ldata;
  logic [9:0] page;
  logic [4:0] word;
  logic [14:0] rvec;
  int fail_count = 0;
  int tests_run = 0;

  // ----------------------------------------------------------------
  // Clock, pins and instances
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rstn, fuse, erase, ext_wr, vecs_ldr} = 5'b00000;
    ext_data = 4'hF;
    gmode = 2'b00;
  end

  core_model u_core (.clk_in(clk), .grant_in(grant), .deny_in(deny),
    .req_valid_out(valid), .req_op_out(op), .pointer_out(ptr),
    .lock_data_out(ldata), .exec_in_loader_out(exec_ldr));

  boot_section_flash_protection u_dut (.ref_clk_in(clk), .resetn_in(rstn),
    .boot_reset_select_fuse_in(fuse), .chip_erase_in(erase),
    .ext_lock_wr_in(ext_wr), .ext_lock_data_in(ext_data),
    .lock_mode_in(gmode), .vectors_in_loader_in(vecs_ldr),
    .exec_in_loader_in(exec_ldr), .req_valid_in(valid), .req_op_in(op),
    .pointer_in(ptr), .lock_data_in(ldata), .grant_out(grant),
    .deny_out(deny), .page_index_field_out(page),
    .word_in_page_field_out(word), .byte_select_bit_out(bsel),
    .op_out(op_q), .lock_bits_out(locks), .reset_vector_out(rvec),
    .irq_enable_out(irq_en));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request from a section; expect grant (1) or deny (0)
  task automatic req(input flash_op_t o, input logic [15:0] p,
                     input logic [7:0] d, input logic ldr, input logic g);
    logic [1:0] ans;
    u_core.place(ldr);
    u_core.issue(o, p, d, ans);
    check(ans, g ? 2'b10 : 2'b01);
  endtask

  // Chip erase pulse long enough to pass the synchroniser
  task automatic erase_all();
    @(posedge clk) erase <= 1'b1;
    repeat (4) @(posedge clk);
    erase <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset(input logic f);
    @(posedge clk) rstn <= 1'b0;
    fuse <= f;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(rvec, f ? 15'h0000 : LOADER_START);
    check(locks, LOCK_ERASED);
    check(op_q, OP_NONE);
    $display("test reset fuse=%0d done", f);
  endtask

  // Erase, load, write and read under every general lock mode, pointer split
  task automatic t_ops();
    flash_op_t seq [4] = '{OP_PAGE_ERASE, OP_BUF_LOAD, OP_PAGE_WRITE,
                           OP_READ};
    logic [15:0] p;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk) gmode <= m[1:0];
      for (int i = 0; i < 4; i++)
      begin
        p = 16'h0ABD + 16'(i * 2);
        req(seq[i], p, 8'hFF, 1'b1, 1'b1);
        check(op_q, seq[i]);
        check(page, p[15:6]);
        check(word, p[5:1]);
        check(bsel, p[0]);
        @(posedge clk);
        #1;
        check(op_q, OP_NONE);
        check(word, p[5:1]);
      end
    end
    @(posedge clk) gmode <= 2'b00;
    req(OP_BUF_LOAD, 16'h0100, 8'hFF, 1'b0, 1'b0);
    req(OP_LOCK_SET, 16'h0001, 8'hC3, 1'b0, 1'b0);
    check(locks, LOCK_ERASED);
    $display("test ops done");
  endtask

  // All four modes of each lock pair
  task automatic t_modes();
    logic [1:0] pr [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [3:0] nib;
    logic [15:0] a;
    for (int s = 0; s < 2; s++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        erase_all();
        nib = s ? {pr[m], 2'b11} : {2'b11, pr[m]};
        a = s ? 16'h1E40 : 16'h0100;
        req(OP_LOCK_SET, 16'hFFFF, {2'b11, nib, 2'b11}, 1'b1, 1'b1);
        check(locks, nib);
        // Write from the loader into the section
        req(OP_PAGE_WRITE, a, 8'hFF, 1'b1, pr[m][0]);
        // Read crossing in from the other section
        req(OP_READ, a, 8'hFF, s == 0, pr[m][1]);
        u_core.place(s[0]);
        @(posedge clk) vecs_ldr <= ~s[0];
        @(posedge clk);
        #1;
        check(irq_en, pr[m][1]);
        @(posedge clk) vecs_ldr <= s[0];
        @(posedge clk);
        #1;
        check(irq_en, 1'b1);
      end
    end
    $display("test modes done");
  endtask

  // Lock bits only ever programmed by writes, cleared by chip erase
  task automatic t_locks();
    erase_all();
    req(OP_LOCK_SET, 16'h0001, 8'hC3, 1'b1, 1'b1);
    req(OP_LOCK_SET, 16'h0001, 8'hFF, 1'b1, 1'b1);
    check(locks, 4'h0);
    check(rvec, 15'h0000);
    erase_all();
    check(locks, LOCK_ERASED);
    @(posedge clk) ext_data <= 4'h7;
    ext_wr <= 1'b1;
    repeat (6) @(posedge clk);
    ext_wr <= 1'b0;
    #1;
    check(locks, 4'h7);
    erase_all();
    check(locks, LOCK_ERASED);
    $display("test locks done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    t_reset(1'b0);
    t_reset(1'b1);
    t_ops();
    t_modes();
    t_locks();
    conclude();
  end

  // Whole run needs a few hundred cycles; cut off well beyond
  initial
  begin
    #200us;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
